// file: core/lpf_fifo.sv
// Pixel FIFO, flip-flop storage, valid/ready on both sides.
// Assumes one clock and synchronous active-low reset.
`default_nettype none
module lpf_fifo #(
  parameter int W     = 18,
  parameter int DEPTH = 32
) (
  input  wire logic         sys_clk_i,
  input  wire logic         resetn_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  logic          push;
  logic          pop;
  assign in_ready_o  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o  = mem_r[rp_r];
  assign push = in_valid_i && in_ready_o;
  assign pop  = out_valid_o && out_ready_i;
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_r[wp_r] <= in_data_i;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= AW'((wp_r + 1'b1) % DEPTH);
      if (pop)  rp_r <= AW'((rp_r + 1'b1) % DEPTH);
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : lpf_fifo
`default_nettype wire

// file: core/lpf_pkg.sv
// Package for the LCD pixel output formatter: register map, format codes,
// timing defaults and carrier structs.
// Assumes one clock domain and a single AHB-Lite master.
`default_nettype none
package lpf_pkg;
  // ==========================================================
  // Register map
  localparam logic [15:0] LPF_FMT_ADDR   = 16'h1104;
  localparam logic [15:0] LPF_HTIM_ADDR  = 16'h1110;
  localparam logic [15:0] LPF_VTIM_ADDR  = 16'h1114;
  localparam logic [15:0] LPF_HPOR_ADDR  = 16'h1118;
  localparam logic [15:0] LPF_VPOR_ADDR  = 16'h111C;
  localparam logic [15:0] LPF_CTRL_ADDR  = 16'h1120;
  localparam logic [15:0] LPF_STAT_ADDR  = 16'h1124;
  localparam logic [15:0] LPF_FMT_RST    = 16'h0000;
  // Format field layout: [4:0] packing code, [8] RGB timing interface
  localparam int          LPF_FMT_RGB_BIT = 8;
  // ==========================================================
  // Packing codes
  localparam logic [4:0] LPF_P6_666    = 5'h00;
  localparam logic [4:0] LPF_P8_332    = 5'h01;
  localparam logic [4:0] LPF_P8_444_XR = 5'h02;
  localparam logic [4:0] LPF_P8_444_RX = 5'h03;
  localparam logic [4:0] LPF_P8_444_BX = 5'h04;
  localparam logic [4:0] LPF_P8_444_XB = 5'h05;
  localparam logic [4:0] LPF_P8_444_PK = 5'h06;
  localparam logic [4:0] LPF_P8_565    = 5'h07;
  localparam logic [4:0] LPF_P8_666_LO = 5'h08;
  localparam logic [4:0] LPF_P8_666_HI = 5'h09;
  localparam logic [4:0] LPF_P9_666    = 5'h0A;
  localparam logic [4:0] LPF_P16_565   = 5'h0B;
  localparam logic [4:0] LPF_P16_332   = 5'h0C;
  localparam logic [4:0] LPF_P16_444_LO = 5'h0D;
  localparam logic [4:0] LPF_P16_444_HI = 5'h0E;
  localparam logic [4:0] LPF_P18_666   = 5'h0F;
  // ==========================================================
  // Timing limits and defaults
  localparam logic [9:0] LPF_MAX_W  = 10'd640;
  localparam logic [9:0] LPF_MAX_H  = 10'd480;
  localparam logic [9:0] LPF_DEF_W  = 10'd640;
  localparam logic [9:0] LPF_DEF_H  = 10'd480;
  localparam logic [7:0] LPF_DEF_POR = 8'h04;
  localparam int         LPF_FIFO_DEPTH = 32;
  localparam int         LPF_FIFO_W     = 18;
  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [5:0] red;
    logic [5:0] green;
    logic [5:0] blue;
  } lpf_pix_s;
  typedef struct packed {
    logic        de;
    logic        hsync;
    logic        vsync;
    logic        wr;
    logic [17:0] data;
  } lpf_lcd_s;
endpackage : lpf_pkg
`default_nettype wire

// file: core/lpf_top.sv
// LCD pixel output formatter: AHB-Lite registers, timing generator, packer.
// Assumes pixels arrive from the frame fetch on the same clock.
//
// Added by the designer: the AHB-Lite interface to the registers.
`default_nettype none
module lpf_top #(
  parameter int FIFO_DEPTH = lpf_pkg::LPF_FIFO_DEPTH
) (
  input  wire logic              sys_clk_i,
  input  wire logic              resetn_i,
  input  wire logic              hsel_i,
  input  wire logic [31:0]       haddr_i,
  input  wire logic [1:0]        htrans_i,
  input  wire logic              hwrite_i,
  input  wire logic [2:0]        hsize_i,
  input  wire logic [31:0]       hwdata_i,
  input  wire logic              hready_i,
  output logic                   hreadyout_o,
  output logic                   hresp_o,
  output logic [31:0]            hrdata_o,
  input  wire logic              pix_valid_i,
  output logic                   pix_ready_o,
  input  wire lpf_pkg::lpf_pix_s pix_i,
  output lpf_pkg::lpf_lcd_s      lcd_o
);
  import lpf_pkg::*;

  typedef enum logic [3:0] {
    LPF_ST_ACT = 4'b0001,
    LPF_ST_FP  = 4'b0010,
    LPF_ST_RT  = 4'b0100,
    LPF_ST_BP  = 4'b1000
  } lpf_tst_e;

  // ==========================================================
  // Register bus
  logic [15:0] fmt_r;
  logic [9:0]  hact_r, vact_r;
  logic [7:0]  hfp_r, hbp_r, hrt_r, vfp_r, vbp_r, vrt_r;
  logic        en_r;
  logic        wph_r;
  logic [15:0] wad_r;
  logic        rgb_if;
  logic [4:0]  pk;
  logic [9:0]  vcnt_r;
  logic [31:0] rdat;

  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign rgb_if = fmt_r[LPF_FMT_RGB_BIT];
  assign pk     = fmt_r[4:0];

  function automatic logic [9:0] lpf_clip(input logic [31:0] v,
                                          input logic [9:0] lim);
    lpf_clip = (v[9:0] > lim || v[9:0] == 10'd0) ? lim : v[9:0];
  endfunction : lpf_clip

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      wph_r <= 1'b0;
      wad_r <= 16'h0000;
    end else if (hready_i) begin
      wph_r <= hsel_i && htrans_i[1] && hwrite_i;
      wad_r <= haddr_i[15:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      fmt_r  <= LPF_FMT_RST;
      hact_r <= LPF_DEF_W;
      vact_r <= LPF_DEF_H;
      {hfp_r, hbp_r, hrt_r} <= {3{LPF_DEF_POR}};
      {vfp_r, vbp_r, vrt_r} <= {3{LPF_DEF_POR}};
      en_r   <= 1'b0;
    end else if (wph_r) begin
      if (wad_r == LPF_FMT_ADDR) begin
        fmt_r <= hwdata_i[15:0];
      end else if (wad_r == LPF_HTIM_ADDR) begin
        hact_r <= lpf_clip(hwdata_i, LPF_MAX_W);
        hrt_r  <= hwdata_i[23:16];
      end else if (wad_r == LPF_VTIM_ADDR) begin
        vact_r <= lpf_clip(hwdata_i, LPF_MAX_H);
        vrt_r  <= hwdata_i[23:16];
      end else if (wad_r == LPF_HPOR_ADDR) begin
        {hbp_r, hfp_r} <= hwdata_i[15:0];
      end else if (wad_r == LPF_VPOR_ADDR) begin
        {vbp_r, vfp_r} <= hwdata_i[15:0];
      end else if (wad_r == LPF_CTRL_ADDR) begin
        en_r <= hwdata_i[0];
      end
    end
  end

  always_comb begin
    if (haddr_i[15:0] == LPF_FMT_ADDR) begin
      rdat = {16'h0000, fmt_r};
    end else if (haddr_i[15:0] == LPF_HTIM_ADDR) begin
      rdat = {8'h00, hrt_r, 6'h00, hact_r};
    end else if (haddr_i[15:0] == LPF_VTIM_ADDR) begin
      rdat = {8'h00, vrt_r, 6'h00, vact_r};
    end else if (haddr_i[15:0] == LPF_HPOR_ADDR) begin
      rdat = {16'h0000, hbp_r, hfp_r};
    end else if (haddr_i[15:0] == LPF_VPOR_ADDR) begin
      rdat = {16'h0000, vbp_r, vfp_r};
    end else if (haddr_i[15:0] == LPF_CTRL_ADDR) begin
      rdat = {31'h0, en_r};
    end else if (haddr_i[15:0] == LPF_STAT_ADDR) begin
      rdat = {22'h0, vcnt_r};
    end else begin
      rdat = 32'h0000_0000;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i) begin
      hrdata_o <= rdat;
    end
  end

  // ==========================================================
  // Pixel FIFO
  logic       f_valid, f_ready;
  logic [17:0] f_data;
  lpf_pix_s   cur, prv_r;

  lpf_fifo #(.W(LPF_FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk_i  (sys_clk_i),
    .resetn_i   (resetn_i),
    .in_valid_i (pix_valid_i),
    .in_ready_o (pix_ready_o),
    .in_data_i  (pix_i),
    .out_valid_o(f_valid),
    .out_ready_i(f_ready),
    .out_data_o (f_data)
  );
  assign cur = lpf_pix_s'(f_data);

  // ==========================================================
  // Timing generator; refresh rate follows the clock rate
  lpf_tst_e hst_r, vst_r;
  logic [9:0] hcnt_r;
  logic       hend, line_end;
  logic       active;

  function automatic logic [9:0] lpf_len(input lpf_tst_e s,
                                         input logic [9:0] a,
                                         input logic [7:0] f,
                                         input logic [7:0] r,
                                         input logic [7:0] b);
    case (s)
      LPF_ST_ACT: lpf_len = a;
      LPF_ST_FP:  lpf_len = {2'b00, f};
      LPF_ST_RT:  lpf_len = {2'b00, r};
      default:    lpf_len = {2'b00, b};
    endcase
  endfunction : lpf_len

  function automatic lpf_tst_e lpf_next(input lpf_tst_e s);
    case (s)
      LPF_ST_ACT: lpf_next = LPF_ST_FP;
      LPF_ST_FP:  lpf_next = LPF_ST_RT;
      LPF_ST_RT:  lpf_next = LPF_ST_BP;
      default:    lpf_next = LPF_ST_ACT;
    endcase
  endfunction : lpf_next

  // Phase counter advances only when a beat is sent
  logic [1:0] ph_r;
  logic [1:0] ph_last;
  logic       beat;

  // Free-running raster in RGB mode; CPU mode writes only as pixels come
  assign active = (hst_r == LPF_ST_ACT) && (vst_r == LPF_ST_ACT);
  assign beat   = en_r && (rgb_if ? active : f_valid);
  assign hend   = (hcnt_r + 10'd1 >= lpf_len(hst_r, hact_r, hfp_r,
                                             hrt_r, hbp_r));
  assign line_end = hend && hst_r == LPF_ST_BP;

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i || !en_r || !rgb_if) begin
      hst_r  <= LPF_ST_ACT;
      hcnt_r <= 10'd0;
    end else if (!active || ph_r == ph_last) begin
      hcnt_r <= hend ? 10'd0 : hcnt_r + 10'd1;
      if (hend) hst_r <= lpf_next(hst_r);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i || !en_r || !rgb_if) begin
      vst_r  <= LPF_ST_ACT;
      vcnt_r <= 10'd0;
    end else if (line_end) begin
      if (vcnt_r + 10'd1 >= lpf_len(vst_r, vact_r, vfp_r, vrt_r, vbp_r)) begin
        vcnt_r <= 10'd0;
        vst_r  <= lpf_next(vst_r);
      end else begin
        vcnt_r <= vcnt_r + 10'd1;
      end
    end
  end

  // ==========================================================
  // Packer
  always_comb begin
    case (pk)
      LPF_P6_666, LPF_P8_666_LO, LPF_P8_666_HI,
      LPF_P8_444_PK:                        ph_last = 2'd2;
      LPF_P8_444_XR, LPF_P8_444_RX, LPF_P8_444_BX, LPF_P8_444_XB,
      LPF_P8_565, LPF_P9_666, LPF_P16_332:  ph_last = 2'd1;
      default:                              ph_last = 2'd0;
    endcase
  end

  // Pop on the last beat of each pixel; packed modes pop mid-group too
  logic pop_mid;
  assign pop_mid = (pk == LPF_P16_332 && ph_r == 2'd0) ||
                   (pk == LPF_P8_444_PK && ph_r == 2'd0);
  assign f_ready = beat && (ph_r == ph_last || pop_mid);

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i || !en_r) begin
      ph_r  <= 2'd0;
      prv_r <= '0;
    end else if (beat) begin
      ph_r <= (ph_r == ph_last) ? 2'd0 : ph_r + 2'd1;
      if (pop_mid) prv_r <= cur;
    end
  end

  // Components of a pixel, truncated to panel depth from the top
  logic [17:0] d;
  always_comb begin
    d = 18'h0;
    case (pk)
      LPF_P6_666: begin
        d[5:0] = ph_r == 2'd0 ? cur.red :
                 ph_r == 2'd1 ? cur.green : cur.blue;
      end
      LPF_P8_332: d[7:0] = {cur.red[5:3], cur.green[5:3],
                            cur.blue[5:4]};
      LPF_P8_444_XR: d[7:0] = ph_r == 2'd0 ? {4'h0, cur.red[5:2]} :
                              {cur.green[5:2], cur.blue[5:2]};
      LPF_P8_444_RX: d[7:0] = ph_r == 2'd0 ? {cur.red[5:2], 4'h0} :
                              {cur.green[5:2], cur.blue[5:2]};
      LPF_P8_444_BX: d[7:0] = ph_r == 2'd0 ?
                              {cur.red[5:2], cur.green[5:2]} :
                              {cur.blue[5:2], 4'h0};
      LPF_P8_444_XB: d[7:0] = ph_r == 2'd0 ?
                              {cur.red[5:2], cur.green[5:2]} :
                              {4'h0, cur.blue[5:2]};
      LPF_P8_444_PK: begin
        d[7:0] = ph_r == 2'd0 ? {cur.red[5:2], cur.green[5:2]} :
                 ph_r == 2'd1 ? {prv_r.blue[5:2], cur.red[5:2]} :
                                {cur.green[5:2], cur.blue[5:2]};
      end
      LPF_P8_565: d[7:0] = ph_r == 2'd0 ?
                           {cur.red[5:1], cur.green[5:3]} :
                           {cur.green[2:0], cur.blue[5:1]};
      LPF_P8_666_LO: d[5:0] = ph_r == 2'd0 ? cur.red :
                     ph_r == 2'd1 ? cur.green : cur.blue;
      LPF_P8_666_HI: d[7:2] = ph_r == 2'd0 ? cur.red :
                     ph_r == 2'd1 ? cur.green : cur.blue;
      LPF_P9_666: d[8:0] = ph_r == 2'd0 ? {cur.red, cur.green[5:3]} :
                           {cur.green[2:0], cur.blue};
      LPF_P16_565: d[15:0] = {cur.red[5:1], cur.green,
                              cur.blue[5:1]};
      LPF_P16_332: d[15:0] = {prv_r.red[5:3], prv_r.green[5:3],
                              prv_r.blue[5:4], cur.red[5:3],
                              cur.green[5:3], cur.blue[5:4]};
      LPF_P16_444_LO: d[11:0] = {cur.red[5:2], cur.green[5:2],
                                 cur.blue[5:2]};
      LPF_P16_444_HI: d[15:4] = {cur.red[5:2], cur.green[5:2],
                                 cur.blue[5:2]};
      default: d = {cur.red, cur.green, cur.blue};
    endcase
  end

  // 16-bit 332 only emits on the beat holding both pixels
  logic emit;
  assign emit = beat && !(pk == LPF_P16_332 && ph_r == 2'd0);

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      lcd_o <= '0;
    end else begin
      lcd_o.de    <= rgb_if && beat;
      lcd_o.wr    <= !rgb_if && emit;
      lcd_o.hsync <= rgb_if && en_r && hst_r == LPF_ST_RT;
      lcd_o.vsync <= rgb_if && en_r && vst_r == LPF_ST_RT;
      lcd_o.data  <= emit ? d : 18'h0;
    end
  end

  // ==========================================================
  // Checks
  sequence s_wr_fmt;
    hsel_i && htrans_i[1] && hwrite_i && hready_i &&
      haddr_i[15:0] == LPF_FMT_ADDR;
  endsequence

  chk_fmt_write: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    s_wr_fmt ##1 1'b1 |=> fmt_r == $past(hwdata_i[15:0]))
    else $error("format register not written");
  chk_width_limit: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    hact_r <= LPF_MAX_W && vact_r <= LPF_MAX_H)
    else $error("active size over limit");
  chk_idle_low: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    !lcd_o.de && !lcd_o.wr |-> lcd_o.data == 18'h0)
    else $error("data lines not low when idle");
  chk_565_pack: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    emit && pk == LPF_P16_565 |=> lcd_o.data[15:11] == $past(cur.red[5:1])
      && lcd_o.data[17:16] == 2'b00)
    else $error("16-bit 565 packing wrong");
  chk_18_pack: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    emit && pk == LPF_P18_666 |=> lcd_o.data == $past(f_data))
    else $error("18-bit packing wrong");
  chk_six_seq: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    beat && pk == LPF_P6_666 && ph_r == 2'd0 |=> ph_r == 2'd1)
    else $error("six-bit phase did not advance");
  chk_565_eight: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    emit && pk == LPF_P8_565 && ph_r == 2'd1
      |=> lcd_o.data[7:5] == $past(cur.green[2:0]))
    else $error("8-bit 565 second beat wrong");
  chk_cpu_no_sync: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    !rgb_if |=> !lcd_o.hsync && !lcd_o.de)
    else $error("sync in CPU mode");
  chk_unused_hi: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    emit && pk == LPF_P9_666
      |=> lcd_o.data[17:9] == 9'h0)
    else $error("9-bit upper lines not low");
endmodule : lpf_top
`default_nettype wire

// file: verification/lcd_pixel_output_formatter_tb_top.sv
// Testbench for the LCD pixel output formatter: packing codes 1 to 15 (all but LPF_P6_666) over the
// CPU interface, the RGB-capable codes over the RGB interface.
// Assumes the design package, FIFO, top and the panel model compile first.
`default_nettype none
module lcd_pixel_output_formatter_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import lpf_pkg::*;
  logic        sys_clk   = 1'b0;
  logic        resetn    = 1'b0;
  logic        hsel      = 1'b0;
  logic [31:0] haddr     = 32'h0;
  logic [1:0]  htrans    = 2'h0;
  logic        hwrite    = 1'b0;
  logic [2:0]  hsize     = 3'h2;
  logic [31:0] hwdata    = 32'h0;
  logic        hready;
  logic        hresp;
  logic [31:0] hrdata;
  logic        pix_valid = 1'b0;
  logic        pix_ready;
  lpf_pix_s    pix       = '0;
  lpf_lcd_s    lcd;
  logic        rgb_mode  = 1'b0;
  logic [17:0] exp_q[$];
  lpf_pix_s    sent[$];
  int          err_total = 0;
  int          comparisons = 0;
  logic [4:0]  rgb_codes[4] = '{LPF_P6_666, LPF_P9_666, LPF_P16_565,
                                LPF_P18_666};

  always #50 sys_clk = ~sys_clk;

  lpf_top #(.FIFO_DEPTH(LPF_FIFO_DEPTH)) dut (
    .sys_clk_i(sys_clk), .resetn_i(resetn), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready),
    .hresp_o(hresp), .hrdata_o(hrdata), .pix_valid_i(pix_valid),
    .pix_ready_o(pix_ready), .pix_i(pix), .lcd_o(lcd));

  lpf_panel_model panel (.sys_clk_i(sys_clk), .resetn_i(resetn),
    .rgb_mode_i(rgb_mode), .lcd_i(lcd));

  // ==========================================================
  // Checking and reporting
  task automatic cmp32(input string what, input logic [31:0] e,
                       input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : cmp32

  task automatic cmp18(input string what, input logic [17:0] e,
                       input logic [17:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : cmp18

  task automatic stop_test;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  // ==========================================================
  // Expected beats, each zero-extended so unused lines read low
  function automatic void put(int n, logic [17:0] a,
                              logic [17:0] b = '0, logic [17:0] c = '0);
    exp_q.push_back(a);
    if (n > 1) exp_q.push_back(b);
    if (n > 2) exp_q.push_back(c);
  endfunction : put

  function automatic void exp_pix(logic [4:0] c, lpf_pix_s p);
    logic [3:0] r, g, b;
    r = p.red[5:2];
    g = p.green[5:2];
    b = p.blue[5:2];
    case (c)
      LPF_P6_666, LPF_P8_666_LO: put(3, p.red, p.green, p.blue);
      LPF_P8_332: put(1, {p.red[5:3], p.green[5:3], p.blue[5:4]});
      LPF_P8_444_XR: put(2, {4'h0, r}, {g, b});
      LPF_P8_444_RX: put(2, {r, 4'h0}, {g, b});
      LPF_P8_444_BX: put(2, {r, g}, {b, 4'h0});
      LPF_P8_444_XB: put(2, {r, g}, {4'h0, b});
      LPF_P8_565: put(2, {p.red[5:1], p.green[5:3]},
                      {p.green[2:0], p.blue[5:1]});
      LPF_P8_666_HI: put(3, {p.red, 2'b0}, {p.green, 2'b0},
                         {p.blue, 2'b0});
      LPF_P9_666: put(2, {p.red, p.green[5:3]},
                      {p.green[2:0], p.blue});
      LPF_P16_565: put(1, {p.red[5:1], p.green, p.blue[5:1]});
      LPF_P16_444_LO: put(1, {r, g, b});
      LPF_P16_444_HI: put(1, {r, g, b, 4'h0});
      LPF_P18_666: put(1, p);
      default: ;
    endcase
  endfunction : exp_pix

  function automatic void exp_pair(logic [4:0] c, lpf_pix_s a, lpf_pix_s b);
    if (c == LPF_P8_444_PK)
      put(3, {a.red[5:2], a.green[5:2]}, {a.blue[5:2], b.red[5:2]},
          {b.green[5:2], b.blue[5:2]});
    else if (c == LPF_P16_332)
      put(1, {a.red[5:3], a.green[5:3], a.blue[5:4],
              b.red[5:3], b.green[5:3], b.blue[5:4]});
    else begin
      exp_pix(c, a);
      exp_pix(c, b);
    end
  endfunction : exp_pair

  // ==========================================================
  // Drivers
  task automatic ahb(input logic [31:0] a, input logic w,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge sys_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic do_reset;
    resetn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
  endtask : do_reset

  // Block is disabled here, so the FIFO must refuse once full
  task automatic fill(output int n);
    logic taken;
    n = 0;
    sent.delete();
    pix_valid <= 1'b1;
    pix       <= lpf_pix_s'(18'($urandom));
    repeat (64) begin
      // Ready is sampled before the edge that takes the pixel
      @(negedge sys_clk);
      taken = pix_ready;
      @(posedge sys_clk);
      if (taken !== 1'b1) break;
      sent.push_back(pix);
      n++;
      pix <= lpf_pix_s'(18'($urandom));
    end
    pix_valid <= 1'b0;
  endtask : fill

  task automatic run(input logic [4:0] c, input logic rgb);
    int          n;
    int          k;
    int          m;
    logic [31:0] rd;
    do_reset();
    rgb_mode <= rgb;
    ahb({16'h0, LPF_FMT_ADDR}, 1'b0, 32'h0, rd);
    cmp32("fmt_reset", {16'h0, LPF_FMT_RST}, rd);
    ahb({16'h0, LPF_FMT_ADDR}, 1'b1, {23'h0, rgb, 3'h0, c}, rd);
    ahb({16'h0, LPF_FMT_ADDR}, 1'b0, 32'h0, rd);
    cmp32("fmt_rw", {23'h0, rgb, 3'h0, c}, rd);
    ahb({16'h0, LPF_HTIM_ADDR}, 1'b1, 32'h0002_0008, rd);
    ahb({16'h0, LPF_VTIM_ADDR}, 1'b1, 32'h0002_0004, rd);
    fill(m);
    cmp32("fifo_fill", 32'(LPF_FIFO_DEPTH), 32'(m));
    exp_q.delete();
    for (k = 0; k + 1 < m; k += 2) exp_pair(c, sent[k], sent[k + 1]);
    // RGB mode compares one short stretch well inside the first frame
    n = rgb ? 24 : exp_q.size();
    ahb({16'h0, LPF_CTRL_ADDR}, 1'b1, 32'h1, rd);
    for (k = 0; k < 3000 && (panel.beats.size() < n ||
                             (rgb && panel.vsync_rises == 0)); k++)
      @(posedge sys_clk);
    // Settle, so a late or surplus beat is counted too
    repeat (8) @(posedge sys_clk);
    // RGB stream never stops, so its count is the first line of 8 pixels
    if (rgb)
      cmp32("line_beats", 32'(8 * exp_q.size() / LPF_FIFO_DEPTH),
            32'(panel.line_beats));
    else
      cmp32("beat_count", 32'(n), 32'(panel.beats.size()));
    for (k = 0; k < n && k < panel.beats.size(); k++)
      cmp18("beat", exp_q[k], panel.beats[k]);
    if (rgb) cmp32("hsync_seen", 32'h1, 32'(panel.hsync_rises > 0));
    if (rgb) cmp32("vsync_seen", 32'h1, 32'(panel.vsync_rises > 0));
  endtask : run

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    logic [31:0] rd;
    void'($urandom(32'hF74F));
    do_reset();
    ahb(32'h0000_1200, 1'b1, 32'hFFFF_FFFF, rd);
    ahb(32'h0000_1200, 1'b0, 32'h0, rd);
    cmp32("unmapped", 32'h0, rd);
    ahb({16'h0, LPF_HPOR_ADDR}, 1'b1, 32'h0000_0605, rd);
    ahb({16'h0, LPF_HPOR_ADDR}, 1'b0, 32'h0, rd);
    cmp32("porch_rw", 32'h0000_0605, rd);
    ahb({16'h0, LPF_HTIM_ADDR}, 1'b1, 32'h0000_03FF, rd);
    ahb({16'h0, LPF_HTIM_ADDR}, 1'b0, 32'h0, rd);
    cmp32("width_clip", 32'(LPF_MAX_W), rd);
    for (int c = 1; c <= 15; c++) run(5'(c), 1'b0);
    foreach (rgb_codes[i]) run(rgb_codes[i], 1'b1);
    stop_test();
  end

  initial begin
    repeat (80000) @(posedge sys_clk);
    err_total++;
    stop_test();
  end
endmodule : lcd_pixel_output_formatter_tb_top
`default_nettype wire

// file: verification/lpf_panel_model.sv
// LCD panel model: records every data beat the formatter presents.
// Assumes the bench tells it which interface the format register selects.
`default_nettype none
module lpf_panel_model (
  input  wire logic              sys_clk_i,
  input  wire logic              resetn_i,
  input  wire logic              rgb_mode_i,
  input  wire lpf_pkg::lpf_lcd_s lcd_i
);
  timeunit 1ns;
  timeprecision 1ns;
  import lpf_pkg::*;
  logic [17:0] beats[$];
  int          hsync_rises;
  int          vsync_rises;
  int          line_beats;
  logic        hsync_q;
  logic        vsync_q;
  // ==========================================================
  // Beat capture
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      beats.delete();
      hsync_rises = 0;
      vsync_rises = 0;
      line_beats  = 0;
    end else begin
      // Memory panel latches only on the write strobe
      if (!rgb_mode_i && lcd_i.wr === 1'b1)
        beats.push_back(lcd_i.data);
      // Memoryless panel takes data while enable is high
      if (rgb_mode_i && lcd_i.de === 1'b1)
        beats.push_back(lcd_i.data);
      if (lcd_i.hsync === 1'b1 && hsync_q !== 1'b1) begin
        // Beats of the first line, counted at its retrace
        if (hsync_rises == 0) line_beats = beats.size();
        hsync_rises++;
      end
      if (lcd_i.vsync === 1'b1 && vsync_q !== 1'b1) vsync_rises++;
    end
    hsync_q = lcd_i.hsync;
    vsync_q = lcd_i.vsync;
  end
endmodule : lpf_panel_model
`default_nettype wire
